// File: hdl/dgp_pin_sync.v
`include "dgp_defs.vh"

module dgp_pin_sync (
  input  wire       i_clk,
  input  wire       i_reset,
  input  wire       i_hold,
  input  wire [7:0] i_pins,
  output wire [7:0] o_sense
);

  // ----------------------------------------------------------------
  // three-stage capture; stage one feeds stage two only
  // ----------------------------------------------------------------
  reg [7:0] meta_q;
  reg [7:0] stage2_q;
  reg [7:0] stage3_q;
  reg [7:0] sense_q;

  // level presented while the buffers are cut, one bit per pin
  localparam [7:0] HOLD_LVL = `DGP_SENSE_HOLD;

  always @(posedge i_clk) begin
    meta_q   <= i_pins;
    stage2_q <= meta_q;
    stage3_q <= stage2_q;
  end

  // a bit moves only once stages two and three agree, so one glitchy
  // sample never reaches software; held constant while buffers are cut
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_bit
      always @(posedge i_clk) begin
        if (i_reset) begin
          sense_q[g] <= 1'b0;
        end else if (i_hold) begin
          sense_q[g] <= HOLD_LVL[g];
        end else if (stage2_q[g] == stage3_q[g]) begin
          sense_q[g] <= stage3_q[g];
        end
      end
    end
  endgenerate

  assign o_sense = sense_q;

endmodule // dgp_pin_sync

// File: hdl/dgp_ports.v
// Notes on behaviour
// - two eight-pin ports, each pin individually directed
// - single-bit set or clear touches only that bit
// - first port latch 1B, direction 1A, sense 19
// - second port latch 18, direction 17, sense 16
// - sense read-only; latch and direction read-write
// - latch read returns latch; sense returns synchronized pins
// - direction one means output, zero means input
// - pull-up on when input and latch one
// - output drives latch value push-pull; else tristate
// - reset tristates pins at once, no clock needed
// - latch and direction reset to all zeros
// - every pin input synchronized before use
// - first port input buffers cut during power-down
// - second port carries timer, comparator and serial pins
// - serial slave forces clock, data-in, select to input
// - serial master forces slave-out pin to input
`include "dgp_defs.vh"

module dgp_ports (
  input  wire       i_clk,
  input  wire       i_reset,
  // i/o space access from the core
  input  wire [5:0] i_io_addr,
  input  wire       i_io_wr,
  input  wire       i_io_rd,
  input  wire [7:0] i_io_wdata,
  input  wire       i_io_bit_set,
  input  wire       i_io_bit_clr,
  input  wire [2:0] i_io_bit_sel,
  output wire [7:0] o_io_rdata,
  output wire       o_io_hit,
  // core state and peripheral modes
  input  wire       i_power_down,
  input  wire       i_spi_enable,
  input  wire       i_spi_master,
  // first port pins
  input  wire [7:0] i_first_port_pin,
  output wire [7:0] o_first_port_pin_out,
  output wire [7:0] o_first_port_pin_oe,
  output wire [7:0] o_first_port_pullup,
  // second port pins
  input  wire [7:0] i_second_port_pin,
  output wire [7:0] o_second_port_pin_out,
  output wire [7:0] o_second_port_pin_oe,
  output wire [7:0] o_second_port_pullup,
  // second port alternate inputs, synchronized
  output wire       o_timer_zero_count_in,
  output wire       o_timer_one_count_in,
  output wire       o_spi_ss_in,
  output wire       o_spi_mosi_in,
  output wire       o_spi_miso_in,
  output wire       o_spi_sck_in
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg  [7:0] first_output_latch_q;
  reg  [7:0] first_output_latch_d;
  reg  [7:0] first_direction_reg_q;
  reg  [7:0] first_direction_reg_d;
  reg  [7:0] second_output_latch_q;
  reg  [7:0] second_output_latch_d;
  reg  [7:0] second_direction_reg_q;
  reg  [7:0] second_direction_reg_d;
  reg  [7:0] rdata_q;
  reg  [7:0] rdata_d;
  reg        hit_q;
  reg        hit_d;
  reg  [7:0] a_out_q;
  reg  [7:0] a_oe_q;
  reg  [7:0] a_pu_q;
  reg  [7:0] b_out_q;
  reg  [7:0] b_oe_q;
  reg  [7:0] b_pu_q;
  reg  [5:0] alt_q;
  wire [7:0] first_pin_sense;
  wire [7:0] second_pin_sense;
  wire [7:0] bit_mask;
  wire [7:0] b_force_in;
  wire [7:0] b_dir_eff;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire sel_a_latch = (i_io_addr == `DGP_A_LATCH_ADDR);
  wire sel_a_dir   = (i_io_addr == `DGP_A_DIR_ADDR);
  wire sel_a_sense = (i_io_addr == `DGP_A_SENSE_ADDR);
  wire sel_b_latch = (i_io_addr == `DGP_B_LATCH_ADDR);
  wire sel_b_dir   = (i_io_addr == `DGP_B_DIR_ADDR);
  wire sel_b_sense = (i_io_addr == `DGP_B_SENSE_ADDR);
  wire sel_any     = sel_a_latch | sel_a_dir | sel_a_sense |
                     sel_b_latch | sel_b_dir | sel_b_sense;

  // one-hot mask of the bit named by a set or clear
  assign bit_mask = 8'h01 << i_io_bit_sel;

  // ----------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------
  // a full write wins over a bit operation in the same cycle; a core
  // never issues both, so the order only matters for a faulty master
  function [7:0] dgp_upd;
    input [7:0] cur;
    input       sel;
    input       wr;
    input       bset;
    input       bclr;
    input [7:0] wdata;
    input [7:0] mask;
    begin
      dgp_upd = cur;
      if (sel && wr) begin
        dgp_upd = wdata;
      end else if (sel && bset) begin
        dgp_upd = cur | mask;
      end else if (sel && bclr) begin
        dgp_upd = cur & ~mask;
      end
    end
  endfunction

  // next values; sense locations have no storage so writes vanish
  always @* begin
    first_output_latch_d   = dgp_upd(first_output_latch_q, sel_a_latch, i_io_wr,
                                     i_io_bit_set, i_io_bit_clr, i_io_wdata, bit_mask);
    first_direction_reg_d  = dgp_upd(first_direction_reg_q, sel_a_dir, i_io_wr,
                                     i_io_bit_set, i_io_bit_clr, i_io_wdata, bit_mask);
    second_output_latch_d  = dgp_upd(second_output_latch_q, sel_b_latch, i_io_wr,
                                     i_io_bit_set, i_io_bit_clr, i_io_wdata, bit_mask);
    second_direction_reg_d = dgp_upd(second_direction_reg_q, sel_b_dir, i_io_wr,
                                     i_io_bit_set, i_io_bit_clr, i_io_wdata, bit_mask);
  end

  // control registers, cleared by the synchronous reset
  always @(posedge i_clk) begin
    if (i_reset) begin
      first_output_latch_q   <= `DGP_LATCH_RST;
      first_direction_reg_q  <= `DGP_DIR_RST;
      second_output_latch_q  <= `DGP_LATCH_RST;
      second_direction_reg_q <= `DGP_DIR_RST;
    end else begin
      first_output_latch_q   <= first_output_latch_d;
      first_direction_reg_q  <= first_direction_reg_d;
      second_output_latch_q  <= second_output_latch_d;
      second_direction_reg_q <= second_direction_reg_d;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // registered read data; idle and unmapped reads give zero
  always @* begin
    rdata_d = `DGP_RDATA_IDLE;
    hit_d   = 1'b0;
    if (i_io_rd) begin
      hit_d = sel_any;
      case (1'b1)
        sel_a_latch: rdata_d = first_output_latch_q;
        sel_a_dir:   rdata_d = first_direction_reg_q;
        sel_a_sense: rdata_d = first_pin_sense;
        sel_b_latch: rdata_d = second_output_latch_q;
        sel_b_dir:   rdata_d = second_direction_reg_q;
        sel_b_sense: rdata_d = second_pin_sense;
        default:     rdata_d = `DGP_RDATA_IDLE;
      endcase
    end
  end

  always @(posedge i_clk) begin
    if (i_reset) begin
      rdata_q <= `DGP_RDATA_IDLE;
      hit_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      hit_q   <= hit_d;
    end
  end

  // ----------------------------------------------------------------
  // input synchronizers
  // ----------------------------------------------------------------
  // first port buffers are cut in power-down so analog levels near
  // mid-rail on the converter inputs toggle nothing
  dgp_pin_sync u_first_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_hold  (i_power_down),
    .i_pins  (i_first_port_pin),
    .o_sense (first_pin_sense)
  );

  // second port keeps sensing; its comparator pins are analog anyway
  dgp_pin_sync u_second_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_hold  (1'b0),
    .i_pins  (i_second_port_pin),
    .o_sense (second_pin_sense)
  );

  // ----------------------------------------------------------------
  // serial port direction overrides
  // ----------------------------------------------------------------
  // slave: clock, data-in and select become inputs; master: data-out
  // of the slave side becomes an input; others follow direction bits
  assign b_force_in[`DGP_B_TIMER0_BIT]  = 1'b0;
  assign b_force_in[`DGP_B_TIMER1_BIT]  = 1'b0;
  assign b_force_in[`DGP_B_CMP_POS_BIT] = 1'b0;
  assign b_force_in[`DGP_B_CMP_NEG_BIT] = 1'b0;
  assign b_force_in[`DGP_B_SS_BIT]      = i_spi_enable & ~i_spi_master;
  assign b_force_in[`DGP_B_MOSI_BIT]    = i_spi_enable & ~i_spi_master;
  assign b_force_in[`DGP_B_MISO_BIT]    = i_spi_enable &  i_spi_master;
  assign b_force_in[`DGP_B_SCK_BIT]     = i_spi_enable & ~i_spi_master;

  assign b_dir_eff = second_direction_reg_q & ~b_force_in;

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // enables and pull-ups clear asynchronously so the pins float the
  // moment reset rises, even with the clock stopped; the pin level
  // flop needs no such path because it is ignored while disabled
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          a_oe_q[g] <= 1'b0;
          a_pu_q[g] <= 1'b0;
          b_oe_q[g] <= 1'b0;
          b_pu_q[g] <= 1'b0;
        end else begin
          a_oe_q[g] <= first_direction_reg_q[g];
          a_pu_q[g] <= ~first_direction_reg_q[g] & first_output_latch_q[g];
          b_oe_q[g] <= b_dir_eff[g];
          b_pu_q[g] <= ~b_dir_eff[g] & second_output_latch_q[g];
        end
      end

      always @(posedge i_clk) begin
        if (i_reset) begin
          a_out_q[g] <= 1'b0;
          b_out_q[g] <= 1'b0;
        end else begin
          a_out_q[g] <= first_output_latch_q[g];
          b_out_q[g] <= second_output_latch_q[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // second port alternate function taps
  // ----------------------------------------------------------------
  // comparator pins are analog and are taken straight from the pad,
  // so only the digital alternates are offered here
  always @(posedge i_clk) begin
    if (i_reset) begin
      alt_q <= 6'h00;
    end else begin
      alt_q <= {second_pin_sense[`DGP_B_SCK_BIT],
                second_pin_sense[`DGP_B_MISO_BIT],
                second_pin_sense[`DGP_B_MOSI_BIT],
                second_pin_sense[`DGP_B_SS_BIT],
                second_pin_sense[`DGP_B_TIMER1_BIT],
                second_pin_sense[`DGP_B_TIMER0_BIT]};
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_io_rdata            = rdata_q;
  assign o_io_hit              = hit_q;
  assign o_first_port_pin_out  = a_out_q;
  assign o_first_port_pin_oe   = a_oe_q;
  assign o_first_port_pullup   = a_pu_q;
  assign o_second_port_pin_out = b_out_q;
  assign o_second_port_pin_oe  = b_oe_q;
  assign o_second_port_pullup  = b_pu_q;
  assign o_timer_zero_count_in = alt_q[0];
  assign o_timer_one_count_in  = alt_q[1];
  assign o_spi_ss_in           = alt_q[2];
  assign o_spi_mosi_in         = alt_q[3];
  assign o_spi_miso_in         = alt_q[4];
  assign o_spi_sck_in          = alt_q[5];

endmodule // dgp_ports

// File: shared/dgp_defs.vh
`ifndef DGP_DEFS_VH
`define DGP_DEFS_VH

// ----------------------------------------------------------------
// i/o space locations (6-bit i/o address)
// ----------------------------------------------------------------
`define DGP_ADDR_W          6
`define DGP_A_LATCH_ADDR    6'h1B
`define DGP_A_DIR_ADDR      6'h1A
`define DGP_A_SENSE_ADDR    6'h19
`define DGP_B_LATCH_ADDR    6'h18
`define DGP_B_DIR_ADDR      6'h17
`define DGP_B_SENSE_ADDR    6'h16

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define DGP_PORT_W          8
`define DGP_LATCH_RST       8'h00
`define DGP_DIR_RST         8'h00
`define DGP_RDATA_IDLE      8'h00
`define DGP_SENSE_HOLD      8'h00

// ----------------------------------------------------------------
// second port alternate function bit positions
// ----------------------------------------------------------------
`define DGP_B_TIMER0_BIT    0
`define DGP_B_TIMER1_BIT    1
`define DGP_B_CMP_POS_BIT   2
`define DGP_B_CMP_NEG_BIT   3
`define DGP_B_SS_BIT        4
`define DGP_B_MOSI_BIT      5
`define DGP_B_MISO_BIT      6
`define DGP_B_SCK_BIT       7

`endif

// File: verif/dgp_pad_model.sv
// external pad: own drive wins, then bench drive, then pull-up; a floating
// line toggles every clock so a missing pull-up never reads as a stable value
module dgp_pad_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_pullup,
  input  wire logic [7:0] i_ext,
  input  wire logic [7:0] i_ext_en,
  output logic      [7:0] o_pad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] float_q = 8'h55;
  always @(posedge i_clk) float_q <= ~float_q;
  always_comb begin
    for (int n = 0; n < 8; n++)
      o_pad[n] = i_oe[n] ? i_out[n] : i_ext_en[n] ? i_ext[n] : i_pullup[n] ? 1'b1 : float_q[n];
  end
endmodule // dgp_pad_model

// File: verif/dgp_ports_properties.sv
module dgp_ports_checker (
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic [5:0] i_io_addr,
  input wire logic       i_io_wr,
  input wire logic       i_io_rd,
  input wire logic [7:0] i_io_wdata,
  input wire logic       i_io_bit_set,
  input wire logic [2:0] i_io_bit_sel,
  input wire logic       i_power_down,
  input wire logic       i_spi_enable,
  input wire logic       i_spi_master,
  input wire logic [7:0] o_io_rdata,
  input wire logic       o_io_hit,
  input wire logic [7:0] o_first_port_pin_oe,
  input wire logic [7:0] o_first_port_pullup,
  input wire logic [7:0] o_second_port_pin_oe,
  input wire logic [7:0] o_second_port_pullup
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // clocking and sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_wr_b; i_io_wr && i_io_addr == 6'h18; endsequence
  sequence s_rd_b; i_io_rd && i_io_addr == 6'h18; endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // pin drivers lag the register by one cycle, so the write shows two edges on
  property p_dir_write;
    i_io_wr && i_io_addr == 6'h1A |-> ##2 o_first_port_pin_oe == $past(i_io_wdata, 2);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write not on enables");
  property p_latch_readback;
    s_wr_b ##1 s_rd_b |=> o_io_rdata == $past(i_io_wdata, 2);
  endproperty
  a_latch_readback: assert property (p_latch_readback) else $error("latch readback wrong");
  property p_bit_set;
    i_io_bit_set && !i_io_wr && i_io_addr == 6'h1A |-> ##2
      o_first_port_pin_oe == ($past(o_first_port_pin_oe) | (8'h01 << $past(i_io_bit_sel, 2)));
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set disturbed other pins");
  property p_hit;
    i_io_rd && i_io_addr inside {[6'h16:6'h1B]} |=> o_io_hit;
  endproperty
  a_hit: assert property (p_hit) else $error("mapped read without hit");
  property p_unmapped;
    i_io_rd && !(i_io_addr inside {[6'h16:6'h1B]}) |=> o_io_rdata == 8'h00 && !o_io_hit;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
  // no clock needed: enables must already be clear whenever reset is seen
  property p_reset_tristate;
    disable iff (1'b0) i_reset |-> (o_first_port_pin_oe | o_first_port_pullup |
      o_second_port_pin_oe | o_second_port_pullup) == 8'h00;
  endproperty
  a_reset_tristate: assert property (p_reset_tristate) else $error("pins driven in reset");
  property p_slave_force;
    (i_spi_enable && !i_spi_master) [*3] |-> (o_second_port_pin_oe & 8'hB0) == 8'h00;
  endproperty
  a_slave_force: assert property (p_slave_force) else $error("slave pins not inputs");
  property p_master_force;
    (i_spi_enable && i_spi_master) [*3] |-> !o_second_port_pin_oe[6];
  endproperty
  a_master_force: assert property (p_master_force) else $error("slave-out pin driven");
  property p_sleep_hold;
    i_power_down [*6] ##0 (i_io_rd && i_io_addr == 6'h19) |=> o_io_rdata == 8'h00;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sense moved in power-down");
endmodule // dgp_ports_checker

// File: verif/tb_dual_gpio_port_a_b.sv
module tb_dual_gpio_port_a_b;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] RD = 4'h8, WR = 4'h4, SET = 4'h2, CLR = 4'h1;
  logic       i_clk = 1'b0, i_reset = 1'b0, rd = 1'b0, wr = 1'b0, bset = 1'b0, bclr = 1'b0;
  logic       pd = 1'b0, spi_en = 1'b0, spi_m = 1'b0, hit;
  logic [5:0] addr = 6'h00;
  wire  [5:0] alt;
  logic [2:0] sel = 3'h0;
  logic [7:0] wdata = 8'h00, rdata, pin_a, out_a, oe_a, pu_a, pin_b, out_b, oe_b, pu_b;
  logic [7:0] ext_a = 8'h00, ext_b = 8'h00, en_a = 8'h00, en_b = 8'h00;
  int         n_mismatch = 0, num_checks = 0;
  initial forever #12.5 i_clk = ~i_clk;
  dgp_ports dut (.i_clk(i_clk), .i_reset(i_reset), .i_io_addr(addr), .i_io_wr(wr),
    .i_io_rd(rd), .i_io_wdata(wdata), .i_io_bit_set(bset), .i_io_bit_clr(bclr),
    .i_io_bit_sel(sel), .o_io_rdata(rdata), .o_io_hit(hit), .i_power_down(pd),
    .i_spi_enable(spi_en), .i_spi_master(spi_m), .i_first_port_pin(pin_a),
    .o_first_port_pin_out(out_a), .o_first_port_pin_oe(oe_a), .o_first_port_pullup(pu_a),
    .i_second_port_pin(pin_b), .o_second_port_pin_out(out_b), .o_second_port_pin_oe(oe_b),
    .o_second_port_pullup(pu_b), .o_timer_zero_count_in(alt[0]),
    .o_timer_one_count_in(alt[1]), .o_spi_ss_in(alt[2]), .o_spi_mosi_in(alt[3]),
    .o_spi_miso_in(alt[4]), .o_spi_sck_in(alt[5]));
  dgp_pad_model u_pad_a (.i_clk(i_clk), .i_out(out_a), .i_oe(oe_a), .i_pullup(pu_a),
    .i_ext(ext_a), .i_ext_en(en_a), .o_pad(pin_a));
  dgp_pad_model u_pad_b (.i_clk(i_clk), .i_out(out_b), .i_oe(oe_b), .i_pullup(pu_b),
    .i_ext(ext_b), .i_ext_en(en_b), .o_pad(pin_b));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask
  // one access per call; request held across exactly one sampling edge
  task automatic io(input logic [3:0] op, input logic [5:0] a, input logic [7:0] d);
    tick(1);
    {rd, wr, bset, bclr} = op;
    addr = a;
    wdata = d;
    sel = d[2:0];
    tick(1);
    {rd, wr, bset, bclr} = 4'h0;
  endtask
  task automatic rdreg(input logic [5:0] a, input logic [7:0] exp);
    io(RD, a, 8'h00);
    chk(rdata, exp);
  endtask
  // write, then read the same location on the very next edge
  task automatic wrrd(input logic [5:0] a, input logic [7:0] d);
    tick(1);
    {rd, wr, bset, bclr} = WR;
    addr = a;
    wdata = d;
    tick(1);
    {rd, wr, bset, bclr} = RD;
    tick(1);
    {rd, wr, bset, bclr} = 4'h0;
    chk(rdata, d);
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rdreg(6'h1B, 8'h00);
    rdreg(6'h1A, 8'h00);
    rdreg(6'h18, 8'h00);
    rdreg(6'h17, 8'h00);
    chk(oe_a | pu_a | oe_b | pu_b, 8'h00);
    io(WR, 6'h1B, 8'hA5); io(WR, 6'h1A, 8'h3C); io(WR, 6'h18, 8'h5A); io(WR, 6'h17, 8'hC3);
    io(WR, 6'h19, 8'hFF); io(WR, 6'h16, 8'hFF);
    rdreg(6'h1B, 8'hA5);
    chk({7'h00, hit}, 8'h01);
    rdreg(6'h1A, 8'h3C); rdreg(6'h18, 8'h5A); rdreg(6'h17, 8'hC3);
    rdreg(6'h20, 8'h00);
    chk({7'h00, hit}, 8'h00);
    chk(oe_a, 8'h3C); chk(oe_b, 8'hC3);
    chk(pu_a, 8'h81); chk(pu_b, 8'h18);
    chk(out_a & oe_a, 8'h24); chk(out_b & oe_b, 8'h42);
    wrrd(6'h18, 8'hC6);
  endtask
  task automatic t_bits;
    io(WR, 6'h1A, 8'h00);
    for (int n = 0; n < 8; n++) begin
      io(SET, 6'h1A, 8'(n));
      tick(1);
      chk(oe_a, 8'((2 << n) - 1));
    end
    for (int n = 0; n < 8; n++) begin
      io(CLR, 6'h1A, 8'(n));
      tick(1);
      chk(oe_a, ~8'((2 << n) - 1));
    end
    // bit operations on the latches leave the neighbouring bits alone
    io(SET, 6'h1B, 8'h06);
    rdreg(6'h1B, 8'hE5);
    io(CLR, 6'h18, 8'h02);
    rdreg(6'h18, 8'hC2);
  endtask
  task automatic t_sense;
    io(WR, 6'h1B, 8'h00); io(WR, 6'h17, 8'h00); io(WR, 6'h18, 8'h00);
    en_a = 8'hFF; en_b = 8'hFF; ext_b = 8'hA6;
    tick(6);
    ext_a = 8'h96; // first-port outputs stay still while pins are sensed
    rdreg(6'h19, 8'h00);
    tick(4);
    rdreg(6'h19, 8'h96);
    rdreg(6'h16, 8'hA6);
    chk({2'b00, alt}, 8'h2A);
    pd = 1'b1;
    tick(8);
    rdreg(6'h19, 8'h00);
    rdreg(6'h16, 8'hA6);
    pd = 1'b0;
    tick(6);
    rdreg(6'h19, 8'h96);
  endtask
  task automatic t_spi;
    en_b = 8'h00;
    io(WR, 6'h17, 8'hFF); io(WR, 6'h18, 8'hFF);
    spi_en = 1'b1;
    tick(4);
    chk(oe_b, 8'h4F); chk(pu_b, 8'hB0);
    spi_m = 1'b1;
    tick(4);
    chk(oe_b, 8'hBF); chk(pu_b, 8'h40);
    spi_en = 1'b0;
    spi_m = 1'b0;
  endtask
  // reset raised between edges must clear the enables before any edge
  task automatic t_async;
    io(WR, 6'h1A, 8'hFF);
    tick(2);
    chk(oe_a, 8'hFF);
    i_reset = 1'b1;
    #1;
    chk(oe_a | oe_b | pu_b, 8'h00);
    tick(2);
    i_reset = 1'b0;
    rdreg(6'h1A, 8'h00);
    rdreg(6'h18, 8'h00);
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    // raise reset after time zero so the asynchronous clear sees an edge
    #1;
    i_reset = 1'b1;
    tick(2);
    i_reset = 1'b0;
    t_regs(); t_bits(); t_sense(); t_spi(); t_async();
    final_report();
  end
  initial begin
    repeat (3000) @(posedge i_clk);
    n_mismatch++;
    final_report();
  end
endmodule // tb_dual_gpio_port_a_b

bind dgp_ports dgp_ports_checker u_chk (.i_clk(i_clk), .i_reset(i_reset),
  .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata),
  .i_io_bit_set(i_io_bit_set), .i_io_bit_sel(i_io_bit_sel), .i_power_down(i_power_down),
  .i_spi_enable(i_spi_enable), .i_spi_master(i_spi_master), .o_io_rdata(o_io_rdata),
  .o_io_hit(o_io_hit), .o_first_port_pin_oe(o_first_port_pin_oe),
  .o_first_port_pullup(o_first_port_pullup), .o_second_port_pin_oe(o_second_port_pin_oe),
  .o_second_port_pullup(o_second_port_pullup));
